// ==== vic_pkg.sv ====
// constants and types for the vectored interrupt controller
package vic_pkg;
    localparam int NSRC = 32;
    localparam int NLVL = 8;
    localparam int AW   = 12;
    localparam int NEV  = 3;
    // register offsets
    localparam logic [11:0] MODE_BASE = 12'h000;
    localparam logic [11:0] VEC_BASE  = 12'h080;
    localparam logic [11:0] CUR_VEC   = 12'h100;
    localparam logic [11:0] FAST_VEC  = 12'h104;
    localparam logic [11:0] CUR_SRC   = 12'h108;
    localparam logic [11:0] PEND      = 12'h10c;
    localparam logic [11:0] MASK      = 12'h110;
    localparam logic [11:0] CORE_STAT = 12'h114;
    localparam logic [11:0] EN_SET    = 12'h120;
    localparam logic [11:0] EN_CLR    = 12'h124;
    localparam logic [11:0] EDGE_CLR  = 12'h128;
    localparam logic [11:0] EDGE_SET  = 12'h12c;
    localparam logic [11:0] END_SVC   = 12'h130;
    localparam logic [11:0] SPUR_VEC  = 12'h134;
    localparam logic [11:0] PROT_CTRL = 12'h138;
    localparam logic [11:0] FF_SET    = 12'h140;
    localparam logic [11:0] FF_CLR    = 12'h144;
    localparam logic [11:0] FF_STAT   = 12'h148;
    localparam logic [11:0] EV_STAT   = 12'h150;
    localparam logic [11:0] EV_MASK   = 12'h154;
    // mode word: priority in [2:0], trigger type in [6:5]
    localparam int MODE_PRI_LSB = 0;
    localparam int MODE_TYP_LSB = 5;
    // trigger type bit 0 = edge, bit 1 = active high (forced for internal sources)
    localparam int TYP_EDGE_BIT = 0;
    localparam int TYP_HIGH_BIT = 1;
    // source map
    localparam int SRC_FAST = 0;
    localparam int SRC_SYS  = 1;
    localparam int SRC_EXT0 = 29;
    localparam logic [31:0] RSV_SRC_MASK = 32'h0001_8000;
    localparam logic [31:0] EXT_SRC_MASK = 32'he000_0001;
    // event bits
    localparam int EV_NEST  = 0;
    localparam int EV_SPUR  = 1;
    localparam int EV_FORCE = 2;
    // reset values
    localparam logic [31:0] VEC_RST  = 32'h0000_0000;
    localparam logic [31:0] SPUR_RST = 32'h0000_0000;
    localparam logic [2:0]  EVM_RST  = 3'h0;
    typedef struct packed {
        logic [1:0] typ;
        logic [2:0] pri;
    } vic_mode_t;
    localparam vic_mode_t MODE_RST = '{typ: 2'h0, pri: 3'h0};
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } vic_bus_t;
endpackage

// ==== vic_ctrl.sv ====
// vectored priority interrupt controller, normal and fast request lines
`timescale 1ns/1ps
module vic_ctrl (
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        sys_ce_in,
    input  wire logic [11:0] addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rd_data_out,
    input  wire logic [31:0] periph_irq_in,
    input  wire logic [6:0]  sys_periph_irq_in,
    input  wire logic        fast_interrupt_input_in,
    input  wire logic [2:0]  ext_request_in,
    output logic             normal_request_n_out,
    output logic             fast_request_n_out,
    output logic             evt_irq_out
);
    localparam int N = vic_pkg::NSRC;
    vic_pkg::vic_bus_t bus;
    vic_pkg::vic_mode_t mode [N];
    vic_pkg::vic_mode_t next_mode [N];
    logic [31:0] vec [N];
    logic [31:0] next_vec [N];
    logic [N-1:0] en, next_en, ffe, next_ffe, edge_pend, next_edge_pend, prev_lvl;
    logic [7:0]  in_svc, next_in_svc;
    logic [4:0]  svc_src [8];
    logic [4:0]  next_svc_src [8];
    logic [31:0] spur, next_spur, next_rd_data;
    logic        prot, next_prot;
    logic [2:0]  ev, next_ev, evm, next_evm;
    logic        next_nreq_n, next_freq_n, next_evt;
    logic [N-1:0] src, lvl, hit, pend, cand;
    logic [2:0]  best_pri, cur_lvl;
    logic [4:0]  best_id;
    logic        best_valid, any_svc, irq_cond, fiq_cond, ack_n, ack_f, tie_bad;

    always_comb begin
        bus = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};
    end

    // external pins on their own numbers
    // fixed source map, reserved held low
    always_comb begin
        src = periph_irq_in & ~vic_pkg::RSV_SRC_MASK & ~vic_pkg::EXT_SRC_MASK;
        src[vic_pkg::SRC_FAST] = fast_interrupt_input_in;
        src[vic_pkg::SRC_SYS] = |sys_periph_irq_in;
        src[vic_pkg::SRC_EXT0 +: 3] = ext_request_in;
    end

    // per-source polarity and edge detection
    // edges are taken on the polarity-adjusted level, so flipping polarity can look like an edge
    for (genvar i = 0; i < N; i++) begin : g_det
        logic hi;
        assign hi = mode[i].typ[vic_pkg::TYP_HIGH_BIT] | ~vic_pkg::EXT_SRC_MASK[i];
        assign lvl[i] = hi ? src[i] : ~src[i];
        assign hit[i] = lvl[i] & ~prev_lvl[i];
        assign pend[i] = vic_pkg::RSV_SRC_MASK[i] ? 1'b0 :
                         (mode[i].typ[vic_pkg::TYP_EDGE_BIT] ? edge_pend[i] : lvl[i]);
    end

    // forced sources leave the normal path
    assign cand = pend & en & ~ffe & ~32'h0000_0001;

    // highest level wins, ties to lowest number
    always_comb begin
        best_pri = 3'h0;
        best_id = 5'h0;
        best_valid = 1'b0;
        for (int i = N - 1; i >= 1; i--) begin
            if (cand[i] && (!best_valid || mode[i].pri >= best_pri)) begin
                best_pri = mode[i].pri;
                best_id = 5'(i);
                best_valid = 1'b1;
            end
        end
    end

    always_comb begin
        cur_lvl = 3'h0;
        for (int p = 0; p < vic_pkg::NLVL; p++) begin
            if (in_svc[p]) begin
                cur_lvl = 3'(p);
            end
        end
        any_svc = |in_svc;
        // preempt only on strictly higher level
        irq_cond = best_valid && (!any_svc || best_pri > cur_lvl);
        // fast path: source 0 plus forced
        fiq_cond = |(pend & en & (ffe | 32'h0000_0001));
        // protected: writing the vector address acknowledges instead
        ack_n = prot ? (bus.wr && bus.addr == vic_pkg::CUR_VEC)
                     : (bus.rd && bus.addr == vic_pkg::CUR_VEC);
        ack_f = !prot && bus.rd && bus.addr == vic_pkg::FAST_VEC;
    end

    always_comb begin
        next_mode = mode;
        next_vec = vec;
        next_en = en;
        next_ffe = ffe;
        next_in_svc = in_svc;
        next_svc_src = svc_src;
        next_spur = spur;
        next_prot = prot;
        next_evm = evm;
        next_ev = ev;
        next_edge_pend = edge_pend;
        next_rd_data = 32'h0000_0000;
        if (bus.wr) begin
            if (bus.addr < vic_pkg::VEC_BASE && bus.addr[1:0] == 2'h0) begin
                // only priority and trigger type are stored, the gap bits read back as zero
                next_mode[bus.addr[6:2]] = '{typ: bus.wdata[vic_pkg::MODE_TYP_LSB +: 2],
                                             pri: bus.wdata[vic_pkg::MODE_PRI_LSB +: 3]};
            end
            if (bus.addr >= vic_pkg::VEC_BASE && bus.addr < vic_pkg::CUR_VEC
                && bus.addr[1:0] == 2'h0) begin
                next_vec[bus.addr[6:2]] = bus.wdata;
            end
            unique case (bus.addr)
                vic_pkg::EN_SET:    next_en = en | bus.wdata;
                vic_pkg::EN_CLR:    next_en = en & ~bus.wdata;
                vic_pkg::EDGE_CLR:  next_edge_pend = edge_pend & ~bus.wdata;
                vic_pkg::END_SVC: begin
                    if (any_svc) begin
                        next_in_svc[cur_lvl] = 1'b0;
                    end
                end
                vic_pkg::SPUR_VEC:  next_spur = bus.wdata;
                vic_pkg::PROT_CTRL: next_prot = bus.wdata[0];
                vic_pkg::FF_SET:    next_ffe = ffe | (bus.wdata & ~32'h0000_0001);
                vic_pkg::FF_CLR:    next_ffe = ffe & ~bus.wdata;
                vic_pkg::EV_STAT:   next_ev = ev & ~bus.wdata[2:0];
                vic_pkg::EV_MASK:   next_evm = bus.wdata[2:0];
                default: ;
            endcase
        end
        if (ack_n) begin
            if (irq_cond) begin
                next_in_svc[best_pri] = 1'b1;
                next_svc_src[best_pri] = best_id;
                next_edge_pend[best_id] = 1'b0;
            end
        end
        if (ack_f) begin
            next_edge_pend = next_edge_pend & ~(ffe | 32'h0000_0001);
        end
        // edge and software set come last so a set beats any clear
        for (int i = 0; i < N; i++) begin
            if (hit[i] && mode[i].typ[vic_pkg::TYP_EDGE_BIT]) begin
                next_edge_pend[i] = 1'b1;
            end
        end
        if (bus.wr && bus.addr == vic_pkg::EDGE_SET) begin
            next_edge_pend = next_edge_pend | bus.wdata;
        end
        if (ack_n && irq_cond && any_svc) begin
            next_ev[vic_pkg::EV_NEST] = 1'b1;
        end
        if (ack_n && !irq_cond) begin
            next_ev[vic_pkg::EV_SPUR] = 1'b1;
        end
        if (|(pend & en & ffe)) begin
            next_ev[vic_pkg::EV_FORCE] = 1'b1;
        end
        if (bus.rd) begin
            if (bus.addr < vic_pkg::VEC_BASE) begin
                next_rd_data = {25'h0, mode[bus.addr[6:2]].typ, 2'h0,
                                mode[bus.addr[6:2]].pri};
            end else if (bus.addr < vic_pkg::CUR_VEC) begin
                next_rd_data = vec[bus.addr[6:2]];
            end else begin
                unique case (bus.addr)
                    vic_pkg::CUR_VEC:   next_rd_data = irq_cond ? vec[best_id] : spur;
                    vic_pkg::FAST_VEC:  next_rd_data = vec[vic_pkg::SRC_FAST];
                    vic_pkg::CUR_SRC:   next_rd_data = {27'h0, any_svc ? svc_src[cur_lvl] : 5'h0};
                    vic_pkg::PEND:      next_rd_data = pend;
                    vic_pkg::MASK:      next_rd_data = en;
                    vic_pkg::CORE_STAT: next_rd_data = {30'h0, ~fast_request_n_out,
                                                        ~normal_request_n_out};
                    vic_pkg::SPUR_VEC:  next_rd_data = spur;
                    vic_pkg::PROT_CTRL: next_rd_data = {31'h0, prot};
                    vic_pkg::FF_STAT:   next_rd_data = ffe;
                    vic_pkg::EV_STAT:   next_rd_data = {29'h0, ev};
                    vic_pkg::EV_MASK:   next_rd_data = {29'h0, evm};
                    default:            next_rd_data = 32'h0000_0000;
                endcase
            end
        end
        next_nreq_n = ~irq_cond;
        next_freq_n = ~fiq_cond;
        next_evt = |(next_ev & next_evm);
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < N; i++) begin
                mode[i] <= vic_pkg::MODE_RST;
                vec[i] <= vic_pkg::VEC_RST;
            end
            for (int p = 0; p < vic_pkg::NLVL; p++) begin
                svc_src[p] <= 5'h0;
            end
            en <= 32'h0000_0000;
            ffe <= 32'h0000_0000;
            edge_pend <= 32'h0000_0000;
            prev_lvl <= 32'h0000_0000;
            in_svc <= 8'h00;
            spur <= vic_pkg::SPUR_RST;
            prot <= 1'b0;
            ev <= 3'h0;
            evm <= vic_pkg::EVM_RST;
            rd_data_out <= 32'h0000_0000;
            normal_request_n_out <= 1'b1;
            fast_request_n_out <= 1'b1;
            evt_irq_out <= 1'b0;
        end else if (sys_ce_in) begin
            mode <= next_mode;
            vec <= next_vec;
            svc_src <= next_svc_src;
            en <= next_en;
            ffe <= next_ffe;
            edge_pend <= next_edge_pend;
            prev_lvl <= lvl;
            in_svc <= next_in_svc;
            spur <= next_spur;
            prot <= next_prot;
            ev <= next_ev;
            evm <= next_evm;
            rd_data_out <= next_rd_data;
            normal_request_n_out <= next_nreq_n;
            fast_request_n_out <= next_freq_n;
            evt_irq_out <= next_evt;
        end
    end

    // checks on the resolver and the request lines
    always_comb begin
        tie_bad = 1'b0;
        for (int i = 1; i < N; i++) begin
            if (best_valid && cand[i] && (mode[i].pri > best_pri
                || (mode[i].pri == best_pri && 5'(i) < best_id))) begin
                tie_bad = 1'b1;
            end
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in || !sys_ce_in);

    pick_order_a: assert property (!tie_bad)
        else $error("resolver picked a wrong source");
    fast_line_a: assert property (pend[0] && en[0] |=> !fast_request_n_out)
        else $error("source 0 did not raise fast request");
    force_out_a: assert property ((cand & ffe) == 32'h0)
        else $error("forced source on normal path");
    reserved_a: assert property (!pend[15] && !pend[16])
        else $error("reserved source pending");
    sys_or_a: assert property (src[1] == (sys_periph_irq_in != 7'h0))
        else $error("system source not the OR");
    nest_req_a: assert property (any_svc && best_valid && best_pri > cur_lvl
        |=> !normal_request_n_out)
        else $error("higher priority did not preempt");
    idle_req_a: assert property (cand == 32'h0 |=> normal_request_n_out)
        else $error("normal request without candidate");
    vec_read_a: assert property (!prot && bus.rd && bus.addr == vic_pkg::CUR_VEC
        && irq_cond |=> rd_data_out == $past(vec[best_id]))
        else $error("vector read returned wrong vector");
    protect_a: assert property (prot && bus.rd && !bus.wr |=> in_svc == $past(in_svc))
        else $error("protected read changed service state");
    mask_a: assert property (!en[5] |-> !cand[5])
        else $error("masked source reached resolver");

    nest_c: cover property (ack_n && irq_cond && any_svc);
    force_c: cover property (|(pend & en & ffe) ##1 !fast_request_n_out);
    spur_c: cover property (ack_n && !irq_cond);
    prot_c: cover property (prot && bus.wr && bus.addr == vic_pkg::CUR_VEC && irq_cond);
endmodule

// ==== vic_core_model.sv ====
// processor core model sampling the two request lines
`timescale 1ns/1ps
module vic_core_model (
    input  wire logic sys_clk_in,
    input  wire logic normal_request_n_in,
    input  wire logic fast_request_n_in,
    output logic      irq_taken_out,
    output logic      fiq_taken_out
);
    // both request lines are active low
    always_ff @(posedge sys_clk_in) begin
        irq_taken_out <= !normal_request_n_in;
        fiq_taken_out <= !fast_request_n_in;
    end
endmodule

// ==== tb_vectored_priority_interrupt_ctrl.sv ====
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module tb_vectored_priority_interrupt_ctrl;
    logic        sys_clk_in, sys_rst_in, wr, rd, fast_interrupt_input, normal_request_n, fast_request_n, evt, irq_tk, fiq_tk, ce;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, periph, v;
    logic [31:0] vec [32];
    logic [6:0]  sysp;
    logic [2:0]  ext;
    logic [7:0]  ty [4] = '{8'h60, 8'h20, 8'h40, 8'h00};
    int          bad_count, n_checks, i, k, s, t, pa, pb;

    vic_ctrl dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .sys_ce_in(ce),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
        .periph_irq_in(periph), .sys_periph_irq_in(sysp), .fast_interrupt_input_in(fast_interrupt_input),
        .ext_request_in(ext), .normal_request_n_out(normal_request_n), .fast_request_n_out(fast_request_n),
        .evt_irq_out(evt));
    vic_core_model core (.sys_clk_in(sys_clk_in), .normal_request_n_in(normal_request_n),
        .fast_request_n_in(fast_request_n), .irq_taken_out(irq_tk), .fiq_taken_out(fiq_tk));

    task automatic test_done();
        if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [11:0] a);
        @(posedge sys_clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // bounded wait on the core model's view of a request line
    task automatic wait_req(input logic fast, input logic lvl);
        for (int n = 0; n < 16; n++) begin
            @(posedge sys_clk_in);
            #1;
            if ((fast ? fiq_tk : irq_tk) === lvl) return;
        end
        bad_count++;
        $display("CHECK FAILED request wait expected %h seen timeout", lvl);
        test_done();
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk_in);
        #1;
    endtask
    // internal sources only: 2..14 and 17..28
    function automatic int pick();
        int r;
        r = 2 + int'($urandom_range(0, 24));
        return (r >= 15) ? r + 2 : r;
    endfunction
    // equal levels go to the lower source number
    function automatic int win(int a, int a_pri, int b, int b_pri);
        if (b_pri > a_pri || (b_pri == a_pri && b < a)) return b;
        else return a;
    endfunction

    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end

    initial begin
        {wr, rd, fast_interrupt_input, addr, wdata, periph, sysp, ext} = '0;
        ce = 1'b1;
        sys_rst_in = 1'b1;
        bad_count = 0;
        n_checks = 0;
        void'($urandom(2118));
        repeat (3) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        #1 chk("normal line", 32'h1, normal_request_n);
        chk("fast line", 32'h1, fast_request_n);
        // external and fast pins idle low: make them active-high levels so they stay quiet
        wreg(vic_pkg::MODE_BASE, 32'h40);
        for (i = 29; i < 32; i++) begin
            wreg(vic_pkg::MODE_BASE + 12'(4 * i), 32'h40);
        end
        // a write while the clock enable is low must be lost
        ce <= 1'b0;
        wreg(vic_pkg::EN_SET, 32'hffff_ffff);
        ce <= 1'b1;
        rreg(vic_pkg::MASK);
        chk("mask reset", 32'h0, v);
        rreg(12'hffc);
        chk("unmapped", 32'h0, v);
        // random pairs, first pair at equal level
        for (k = 0; k < 6; k++) begin
            s = pick();
            do t = pick(); while (t == s);
            pa = int'($urandom_range(0, 7));
            pb = (k == 0) ? pa : int'($urandom_range(0, 7));
            vec[s] = $urandom();
            vec[t] = $urandom();
            wreg(vic_pkg::MODE_BASE + 12'(4 * s), 32'(pa));
            wreg(vic_pkg::MODE_BASE + 12'(4 * t), 32'(pb));
            wreg(vic_pkg::VEC_BASE + 12'(4 * s), vec[s]);
            wreg(vic_pkg::VEC_BASE + 12'(4 * t), vec[t]);
            wreg(vic_pkg::EN_SET, (32'h1 << s) | (32'h1 << t));
            @(posedge sys_clk_in);
            periph <= (32'h1 << s) | (32'h1 << t);
            wait_req(1'b0, 1'b1);
            rreg(vic_pkg::CUR_VEC);
            chk("vector", vec[win(s, pa, t, pb)], v);
            wait_req(1'b0, 1'b0);
            periph <= '0;
            wreg(vic_pkg::END_SVC, 32'h0);
            wreg(vic_pkg::EN_CLR, 32'hffff_ffff);
        end
        // nesting, protect mode and the event interrupt
        wreg(vic_pkg::MODE_BASE + 12'h00c, 32'h2);
        wreg(vic_pkg::MODE_BASE + 12'h050, 32'h5);
        wreg(vic_pkg::VEC_BASE + 12'h00c, 32'h0000_0333);
        wreg(vic_pkg::VEC_BASE + 12'h050, 32'h0000_5020);
        wreg(vic_pkg::EN_SET, 32'h0010_0008);
        periph <= 32'h0000_0008;
        wait_req(1'b0, 1'b1);
        wreg(vic_pkg::PROT_CTRL, 32'h1);
        rreg(vic_pkg::CUR_VEC);
        rreg(vic_pkg::CUR_VEC);
        chk("protected vector", 32'h0000_0333, v);
        @(posedge sys_clk_in);
        #1 chk("read data drop", 32'h0, rdata);
        settle();
        chk("no ack in protect", 32'h1, irq_tk);
        wreg(vic_pkg::CUR_VEC, 32'h0);
        wreg(vic_pkg::PROT_CTRL, 32'h0);
        wait_req(1'b0, 1'b0);
        periph <= 32'h0010_0008;
        wait_req(1'b0, 1'b1);
        rreg(vic_pkg::CUR_VEC);
        chk("nested vector", 32'h0000_5020, v);
        rreg(vic_pkg::CUR_SRC);
        chk("current source", 32'h14, v);
        rreg(vic_pkg::EV_STAT);
        chk("nest event", 32'h1, v & 32'h1);
        wreg(vic_pkg::EV_MASK, 32'h1);
        settle();
        chk("event line", 32'h1, evt);
        wreg(vic_pkg::EV_MASK, 32'h0);
        settle();
        chk("event masked", 32'h0, evt);
        wreg(vic_pkg::EV_STAT, 32'h1);
        rreg(vic_pkg::EV_STAT);
        chk("event cleared", 32'h0, v & 32'h1);
        periph <= '0;
        wreg(vic_pkg::END_SVC, 32'h0);
        wreg(vic_pkg::END_SVC, 32'h0);
        wreg(vic_pkg::EN_CLR, 32'hffff_ffff);
        // reserved sources never pend
        wreg(vic_pkg::EN_SET, vic_pkg::RSV_SRC_MASK);
        periph <= vic_pkg::RSV_SRC_MASK;
        settle();
        rreg(vic_pkg::PEND);
        chk("reserved pend", 32'h0, v);
        chk("reserved line", 32'h0, irq_tk);
        periph <= '0;
        // source 1 used for interrupt control only
        wreg(vic_pkg::EN_SET, 32'h2);
        for (i = 0; i < 7; i++) begin
            sysp <= 7'(1 << i);
            settle();
            rreg(vic_pkg::PEND);
            chk("system source", 32'h2, v & 32'h2);
        end
        sysp <= '0;
        wreg(vic_pkg::EN_CLR, 32'hffff_ffff);
        // internal edge mode latches a one-cycle pulse
        s = pick();
        wreg(vic_pkg::MODE_BASE + 12'(4 * s), 32'h21);
        wreg(vic_pkg::EN_SET, 32'h1 << s);
        @(posedge sys_clk_in);
        periph <= 32'h1 << s;
        @(posedge sys_clk_in);
        periph <= '0;
        settle();
        rreg(vic_pkg::PEND);
        chk("edge latched", 32'h1 << s, v);
        wreg(vic_pkg::EDGE_CLR, 32'hffff_ffff);
        rreg(vic_pkg::PEND);
        chk("edge cleared", 32'h0, v);
        wreg(vic_pkg::EDGE_SET, 32'h1 << s);
        rreg(vic_pkg::PEND);
        chk("edge set", 32'h1 << s, v);
        wreg(vic_pkg::EDGE_CLR, 32'hffff_ffff);
        wreg(vic_pkg::EN_CLR, 32'hffff_ffff);
        // every trigger type on every external pin
        for (i = 0; i < 3; i++) begin
            for (k = 0; k < 4; k++) begin
                ext <= (k % 2 == 1) ? 3'(1 << i) : 3'h0;
                wreg(vic_pkg::MODE_BASE + 12'(4 * (29 + i)), 32'(ty[k]));
                wreg(vic_pkg::EDGE_CLR, 32'hffff_ffff);
                wreg(vic_pkg::EN_SET, 32'h1 << (29 + i));
                settle();
                rreg(vic_pkg::PEND);
                chk("ext idle", 32'h0, v);
                ext[i] <= ~ext[i];
                settle();
                rreg(vic_pkg::PEND);
                chk("ext active", 32'h1 << (29 + i), v);
                ext[i] <= ~ext[i];
                settle();
                rreg(vic_pkg::PEND);
                chk("ext released", ty[k][5] ? 32'h1 << (29 + i) : 32'h0, v);
                wreg(vic_pkg::EN_CLR, 32'hffff_ffff);
            end
            // back to an active-high level so the pin stays quiet while idle low
            wreg(vic_pkg::MODE_BASE + 12'(4 * (29 + i)), 32'h40);
        end
        ext <= '0;
        // fast input and fast forcing
        wreg(vic_pkg::MODE_BASE, 32'h40);
        wreg(vic_pkg::EN_SET, 32'h1);
        fast_interrupt_input <= 1'b1;
        wait_req(1'b1, 1'b1);
        chk("fast not normal", 32'h0, irq_tk);
        fast_interrupt_input <= 1'b0;
        wait_req(1'b1, 1'b0);
        s = pick();
        wreg(vic_pkg::MODE_BASE + 12'(4 * s), 32'h7);
        wreg(vic_pkg::EN_SET, 32'h1 << s);
        wreg(vic_pkg::FF_SET, 32'h1 << s);
        periph <= 32'h1 << s;
        wait_req(1'b1, 1'b1);
        settle();
        chk("forced off normal", 32'h0, irq_tk);
        periph <= '0;
        wait_req(1'b1, 1'b0);
        wreg(vic_pkg::FF_CLR, 32'hffff_ffff);
        // fast vector readback and a spurious acknowledge with nothing pending
        vec[0] = $urandom();
        vec[1] = $urandom();
        wreg(vic_pkg::VEC_BASE, vec[0]);
        wreg(vic_pkg::SPUR_VEC, vec[1]);
        rreg(vic_pkg::FAST_VEC);
        chk("fast vector", vec[0], v);
        rreg(vic_pkg::CUR_VEC);
        chk("spurious vector", vec[1], v);
        rreg(vic_pkg::EV_STAT);
        chk("spurious event", 32'h2, v & 32'h2);
        test_done();
    end
endmodule
